// ===== sfl_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sfl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,      // Clock
    input  wire             nrst,      // Async reset, active low
    input  wire             ce,        // Clock enable
    input  wire [WIDTH-1:0] in_data,   // Fill data
    input  wire             in_valid,  // Fill valid
    output wire             in_ready,  // Not full
    output wire [WIDTH-1:0] out_data,  // Head word
    output wire             out_valid, // Not empty
    input  wire             out_ready  // Drain accept
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    // Honest flags from occupancy count
    assign in_ready  = (cnt_reg != DEPTH);
    assign out_valid = (cnt_reg != 0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // Pointers wrap at DEPTH so non-power-of-two depths also work
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // Storage carries no reset; only counted words are ever read
    always @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule

// ===== sfl_framer.v
// Line frame builder: lays ATM cells into a multi-unit SONET frame, byte by byte
`timescale 1ns/1ps
`include "sfl_map.vh"
module sfl_framer #(
    parameter NUNITS       = `SFL_UNITS_12,
    parameter FRAME_CYCLES = `SFL_FRAME_CYCLES,
    parameter FIFO_DEPTH   = `SFL_FIFO_DEPTH
) (
    input  wire       mclk,          // Line byte clock
    input  wire       nrst,          // Async reset, active low
    input  wire       ce,            // Clock enable, freezes all state
    input  wire       concat_mode,   // 1 = concatenated format, 12-unit format only
    input  wire       fmt_3unit,     // 1 = 3-unit format, 0 = 12-unit
    input  wire [9:0] poh_start,     // Envelope offset of path overhead column
    input  wire [7:0] cell_data,     // Cell byte from cell processor
    input  wire       cell_valid,    // Cell byte valid
    input  wire       cell_sop,      // First byte of a cell
    output wire       cell_ready,    // FIFO has room
    output reg  [7:0] line_data,     // Line byte out
    output reg        line_frame,    // Pulse with first A2 byte
    output reg        line_payload,  // Byte is envelope content
    output reg        line_cell_sop, // Byte is first header byte of a cell
    output reg        line_tick      // Pulse at each frame period boundary
);
    localparam UCOLS     = `SFL_UNIT_COLS;
    localparam ROWS      = `SFL_ROWS;
    localparam CELL      = `SFL_CELL_BYTES;
    localparam ST_FILL   = 1'b0;
    localparam ST_CELL   = 1'b1;
    localparam [10:0] UCOLS_W = `SFL_UNIT_COLS;

    // Active units; single unit is not a legal format
    wire [3:0]  units = fmt_3unit ? 4'd3 : 4'd12;
    reg  [3:0]  row_reg;
    reg  [10:0] col_reg;
    reg  [5:0]  cidx_reg;
    reg         cst_reg;
    reg  [12:0] tick_reg;
    reg  [9:0]  poh_reg;
    reg         concat_reg;
    reg  [3:0]  units_reg;

    // Row length follows the latched format so a mid-frame switch cannot overrun the row
    wire [10:0] ncols = {7'd0, units_reg} * UCOLS_W;

    wire [7:0]  fifo_data;
    wire        fifo_valid;
    wire        fifo_pop;

    // Column within a unit: interleave across units column by column
    function [1:0] toh_col;
        input [10:0] col;
        input [3:0]  nu;
        begin
            if (col < nu) begin
                toh_col = 2'd0;
            end else if (col < 2 * nu) begin
                toh_col = 2'd1;
            end else if (col < 3 * nu) begin
                toh_col = 2'd2;
            end else begin
                toh_col = 2'd3;
            end
        end
    endfunction

    wire [1:0]  tcol    = toh_col(col_reg, units_reg);
    wire        is_toh  = (tcol != 2'd3);
    wire [3:0]  unit_ix = col_reg[3:0] - (tcol == 2'd0 ? 4'd0 :
                          (tcol == 2'd1 ? units_reg : units_reg + units_reg));
    wire [10:0] spe_col = col_reg - {7'd0, units_reg} * 11'd3;
    // Path overhead column floats; set once per frame
    wire        is_poh  = !is_toh && (spe_col[10:0] == {1'b0, poh_reg} );
    wire        is_cell = !is_toh && !is_poh;
    wire        last_col = (col_reg == ncols - 1'b1);

    // Transport overhead byte for unit position, row and column
    reg [7:0] toh_byte;
    always @* begin
        toh_byte = `SFL_IDLE_BYTE;
        if (row_reg == 4'd0 && tcol == 2'd0) begin
            toh_byte = `SFL_A1_BYTE;
        end else if (row_reg == 4'd0 && tcol == 2'd1) begin
            toh_byte = `SFL_A2_BYTE;
        end else if (row_reg == 4'd3 && tcol == 2'd0) begin
            // Later units of a concatenated frame carry the indicator
            toh_byte = (concat_reg && unit_ix != 4'd0) ? `SFL_H1_CONCAT
                                                       : `SFL_H1_NORMAL;
        end else if (row_reg == 4'd3 && tcol == 2'd1) begin
            toh_byte = (concat_reg && unit_ix != 4'd0) ? `SFL_H2_CONCAT
                                                       : `SFL_IDLE_BYTE;
        end
    end

    wire cell_sop_head;

    // Cell bytes drain only in cell slots and only mid-cell or on a fresh cell head
    assign fifo_pop = ce && is_cell && fifo_valid &&
                      (cst_reg == ST_CELL || cell_sop_head);

    sfl_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .ce        (ce),
        .in_data   ({cell_sop, cell_data}),
        .in_valid  (cell_valid),
        .in_ready  (cell_ready),
        .out_data  ({cell_sop_head, fifo_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Row and column counters, frame-start latch of format and path overhead
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            row_reg    <= 4'd0;
            col_reg    <= 11'd0;
            poh_reg    <= 10'd0;
            concat_reg <= 1'b0;
            units_reg  <= 4'd12;
        end else if (ce) begin
            if (last_col) begin
                col_reg <= 11'd0;
                if (row_reg == ROWS - 1) begin
                    row_reg    <= 4'd0;
                    poh_reg    <= (poh_start < UCOLS - 3) ? poh_start : 10'd0;
                    concat_reg <= concat_mode & ~fmt_3unit;
                    units_reg  <= units;
                end else begin
                    row_reg <= row_reg + 1'b1;
                end
            end else begin
                col_reg <= col_reg + 1'b1;
            end
        end
    end

    // Cell byte count: 5 header plus 48 payload, back to back
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cidx_reg <= 6'd0;
            cst_reg  <= ST_FILL;
        end else if (ce && fifo_pop) begin
            case (cst_reg)
                ST_FILL: begin
                    cidx_reg <= 6'd1;
                    cst_reg  <= ST_CELL;
                end
                default: begin
                    if (cidx_reg == CELL - 1) begin
                        cidx_reg <= 6'd0;
                        cst_reg  <= ST_FILL;
                    end else begin
                        cidx_reg <= cidx_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // Frame period tick, kept apart from byte count for rate checking
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tick_reg  <= 13'd0;
            line_tick <= 1'b0;
        end else if (ce) begin
            if (tick_reg == FRAME_CYCLES - 1) begin
                tick_reg  <= 13'd0;
                line_tick <= 1'b1;
            end else begin
                tick_reg  <= tick_reg + 1'b1;
                line_tick <= 1'b0;
            end
        end
    end

    // Registered line outputs; idle fill when no cell is ready keeps the line alive
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            line_data     <= `SFL_IDLE_BYTE;
            line_frame    <= 1'b0;
            line_payload  <= 1'b0;
            line_cell_sop <= 1'b0;
        end else if (ce) begin
            line_frame    <= (row_reg == 4'd0) && (col_reg == {7'd0, units_reg});
            line_payload  <= !is_toh;
            line_cell_sop <= fifo_pop && cst_reg == ST_FILL;
            if (is_toh) begin
                line_data <= toh_byte;
            end else if (is_poh) begin
                line_data <= `SFL_IDLE_BYTE;
            end else if (fifo_pop) begin
                line_data <= fifo_data;
            end else begin
                line_data <= `SFL_IDLE_BYTE;
            end
        end
    end
endmodule

// ===== sfl_framer_props.sv
// Concurrent checks on the line frame builder ports
`timescale 1ns/1ps
module sfl_framer_chk #(
    parameter FRAME_CYCLES = 1250
) (
    input wire       mclk,          // Line byte clock
    input wire       nrst,          // Reset, active low
    input wire       fmt_3unit,     // Format select
    input wire [7:0] line_data,     // Line byte
    input wire       line_frame,    // Frame pulse
    input wire       line_payload,  // Envelope byte
    input wire       line_cell_sop, // Cell start
    input wire       line_tick      // Period pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    reg [15:0] fcnt_reg;
    reg [15:0] tcnt_reg;
    reg [15:0] pcnt_reg;
    reg [2:0]  seen_reg;
    reg [1:0]  skip_reg;
    reg        fmt_reg;
    // Distances since last frame, tick and cell; a format switch spoils one of the next two frame spans
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fcnt_reg <= 16'h0000;
            tcnt_reg <= 16'h0000;
            pcnt_reg <= 16'h0000;
            seen_reg <= 3'h0;
            skip_reg <= 2'h0;
            fmt_reg <= 1'b0;
        end else begin
            fcnt_reg <= line_frame ? 16'h0000 : fcnt_reg + 16'h0001;
            tcnt_reg <= line_tick ? 16'h0000 : tcnt_reg + 16'h0001;
            pcnt_reg <= line_cell_sop ? 16'h0000 : pcnt_reg + {15'h0000, line_payload};
            seen_reg <= seen_reg | {line_cell_sop, line_tick, line_frame};
            fmt_reg <= fmt_3unit;
            if (fmt_reg != fmt_3unit)
                skip_reg <= 2'h2;
            else if (line_frame && skip_reg != 2'h0)
                skip_reg <= skip_reg - 2'h1;
        end
    end
    property p_align;
        line_frame |-> line_data == 8'h28 && $past(line_data, 3) == 8'hf6;
    endproperty
    property p_frame_len;
        line_frame && seen_reg[0] && skip_reg == 2'h0 |->
            fcnt_reg == 16'd9719 || fcnt_reg == 16'd2429;
    endproperty
    property p_frame_pulse;
        line_frame |=> !line_frame;
    endproperty
    property p_ovh_run;
        line_frame |-> (!line_payload) [*6];
    endproperty
    property p_tick_len;
        line_tick && seen_reg[1] |-> tcnt_reg == FRAME_CYCLES - 1;
    endproperty
    property p_tick_pulse;
        line_tick |=> !line_tick;
    endproperty
    property p_cell_len;
        line_cell_sop && seen_reg[2] |-> pcnt_reg >= 16'd52;
    endproperty
    property p_cell_env;
        line_cell_sop |-> line_payload;
    endproperty
    a_align:       assert property (p_align) else $error("frame word wrong");
    a_frame_len:   assert property (p_frame_len) else $error("frame length wrong");
    a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse long");
    a_ovh_run:     assert property (p_ovh_run) else $error("overhead run short");
    a_tick_len:    assert property (p_tick_len) else $error("tick period wrong");
    a_tick_pulse:  assert property (p_tick_pulse) else $error("tick pulse long");
    a_cell_len:    assert property (p_cell_len) else $error("cell too short");
    a_cell_env:    assert property (p_cell_env) else $error("cell outside envelope");
    c_frame: cover property (line_frame && seen_reg[0]);
    c_tick:  cover property (line_tick && seen_reg[1]);
    c_cell:  cover property (line_cell_sop && seen_reg[2]);
endmodule
bind sfl_framer sfl_framer_chk #(.FRAME_CYCLES(FRAME_CYCLES)) chk_u (
    .mclk(mclk), .nrst(nrst), .fmt_3unit(fmt_3unit), .line_data(line_data),
    .line_frame(line_frame), .line_payload(line_payload),
    .line_cell_sop(line_cell_sop), .line_tick(line_tick));

// ===== sfl_line_model.sv
// Line side receiver model: frame length and A1 run capture, pointer capture and cell byte capture
`timescale 1ns/1ps
module sfl_line_model (
    input wire        mclk,          // Line byte clock
    input wire [7:0]  line_data,     // Received byte
    input wire        line_frame,    // Frame pulse
    input wire        line_payload,  // Envelope byte
    input wire        line_cell_sop, // Cell start
    input wire [15:0] h1_off         // Offset of first pointer byte from frame pulse
);
    integer   off_reg = 0;
    integer   run_reg = 0;
    integer   frame_len = 0;
    integer   a1_run = 0;
    integer   n_sop = 0;
    reg [7:0] h1_a = 8'h00;
    reg [7:0] h1_b = 8'h00;
    reg [7:0] cap[$];
    // Idle and path overhead are 00, so nonzero envelope bytes can only be cell bytes
    always @(posedge mclk) begin
        run_reg <= (line_data == 8'hf6) ? run_reg + 1 : 0;
        off_reg <= line_frame ? 1 : off_reg + 1;
        if (line_frame) begin
            frame_len <= off_reg;
            a1_run <= run_reg;
        end
        if (off_reg == h1_off) h1_a <= line_data;
        if (off_reg == h1_off + 1) h1_b <= line_data;
        if (line_payload && line_data != 8'h00) cap.push_back(line_data);
        if (line_cell_sop) n_sop <= n_sop + 1;
    end
endmodule

// ===== sfl_map.vh
// Frame geometry, framing constants and timing counts for the line frame builder
`ifndef SFL_MAP_VH
`define SFL_MAP_VH
`define SFL_ROWS          9
`define SFL_UNIT_COLS     90
`define SFL_UNITS_12      12
`define SFL_UNITS_3       3
`define SFL_TOH_COLS      3
`define SFL_SOH_BYTES     9
`define SFL_LOH_BYTES     18
`define SFL_POH_BYTES     9
`define SFL_CELL_BYTES    53
`define SFL_HDR_BYTES     5
`define SFL_FRAME_US      125
`define SFL_FRAMES_PER_S  8000
`define SFL_CLK_MHZ       10
`define SFL_FRAME_CYCLES  (`SFL_FRAME_US * `SFL_CLK_MHZ)
`define SFL_A1_BYTE       8'hf6
`define SFL_A2_BYTE       8'h28
`define SFL_H1_NORMAL     8'h60
`define SFL_H1_CONCAT     8'h93
`define SFL_H2_CONCAT     8'hff
`define SFL_IDLE_BYTE     8'h00
`define SFL_FIFO_DEPTH    8
`endif

// ===== test_sonet_sts12_frame_layout.sv
// Self-checking bench for the line frame builder
`timescale 1ns/1ps
module test_sonet_sts12_frame_layout;
    reg        mclk = 1'b0;
    reg        nrst = 1'b0;
    reg        concat_mode = 1'b0;
    reg        fmt_3unit = 1'b0;
    reg  [7:0] cell_data = 8'h00;
    reg        cell_valid = 1'b0;
    reg        cell_sop = 1'b0;
    wire       cell_ready, line_frame, line_payload, line_cell_sop, line_tick;
    wire [7:0] line_data;
    integer    miscompares = 0;
    integer    n_compared = 0;
    integer    i;
    always #50 mclk = ~mclk;
    // Short tick period gives many tick checks in the run
    sfl_framer #(.FRAME_CYCLES(64)) dut_u (.mclk(mclk), .nrst(nrst), .ce(1'b1),
        .concat_mode(concat_mode), .fmt_3unit(fmt_3unit), .poh_start(10'h056),
        .cell_data(cell_data), .cell_valid(cell_valid), .cell_sop(cell_sop),
        .cell_ready(cell_ready), .line_data(line_data), .line_frame(line_frame),
        .line_payload(line_payload), .line_cell_sop(line_cell_sop), .line_tick(line_tick));
    sfl_line_model line_u (.mclk(mclk), .line_data(line_data), .line_frame(line_frame),
        .line_payload(line_payload), .line_cell_sop(line_cell_sop), .h1_off(16'd3228));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
                miscompares = miscompares + 1;
            end
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Returns on the falling edge after the n-th frame pulse has been latched
    task wait_frames(input integer n);
        begin
            repeat (n) begin
                @(negedge mclk);
                while (line_frame !== 1'b1) @(negedge mclk);
            end
            @(negedge mclk);
        end
    endtask
    // Ready is looked at mid-cycle, so the byte is held until the edge that takes it
    task send_cell(input [7:0] base);
        integer k;
        begin
            for (k = 0; k < 53; k = k + 1) begin
                cell_data <= base + k[7:0];
                cell_valid <= 1'b1;
                cell_sop <= (k == 0);
                @(negedge mclk);
                while (cell_ready !== 1'b1) @(negedge mclk);
                @(posedge mclk);
            end
        end
    endtask
    task t_reset;
        begin
            @(negedge mclk);
            chk("line_data", 8'h00, line_data);
            chk("cell_ready", 1'b1, cell_ready);
            repeat (4) @(posedge mclk);
            nrst <= 1'b1;
        end
    endtask
    task t_frame12;
        begin
            wait_frames(2);
            chk("frame_len", 9720, line_u.frame_len);
            chk("a1_run", 12, line_u.a1_run);
            chk("h1_u0", 8'h60, line_u.h1_a);
            chk("h1_u1", 8'h60, line_u.h1_b);
        end
    endtask
    task t_concat;
        begin
            @(posedge mclk);
            concat_mode <= 1'b1;
            wait_frames(3);
            chk("h1_u0", 8'h60, line_u.h1_a);
            chk("h1_u1", 8'h93, line_u.h1_b);
            @(posedge mclk);
            concat_mode <= 1'b0;
        end
    endtask
    task t_fmt3;
        begin
            @(posedge mclk);
            fmt_3unit <= 1'b1;
            wait_frames(3);
            chk("frame_len", 2430, line_u.frame_len);
            chk("a1_run", 3, line_u.a1_run);
        end
    endtask
    task t_cells;
        begin
            @(posedge mclk);
            send_cell(8'h01);
            send_cell(8'h36);
            cell_valid <= 1'b0;
            wait_frames(2);
            chk("cap_size", 106, line_u.cap.size());
            for (i = 0; i < 106; i = i + 1)
                chk("cell_byte", i + 1, line_u.cap[i]);
            chk("n_sop", 2, line_u.n_sop);
        end
    endtask
    initial begin
        t_reset;
        t_frame12;
        t_concat;
        t_fmt3;
        t_cells;
        end_of_test;
    end
    // Roughly 58000 cycles are needed; this cuts a hang short
    initial begin
        repeat (95000) @(posedge mclk);
        miscompares = miscompares + 1;
        end_of_test;
    end
endmodule
